// ---- rdss_top.sv ----
// Purpose: Decodes the programmable input terminals into run, direction and speed target.
// Assumes: Terminal levels are raw electrical states; polarity bits say which are normally closed.
// Notes: Registers are reached over a plain address/strobe port with read data one cycle later.
`default_nettype none
module rdss_top (
  input wire logic clock,
  input wire logic srst,
  input wire logic clock_en,
  input wire logic [rdss_pkg::RDSS_NUM_TERMS-1:0] terminal_in,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic motor_run,
  output logic motor_reverse,
  output logic [rdss_pkg::RDSS_IDX_W-1:0] speed_index,
  output logic [rdss_pkg::RDSS_FREQ_W-1:0] target_frequency,
  output var rdss_pkg::rdss_cmd_t command
);
  import rdss_pkg::*;

  logic [RDSS_NUM_TERMS-1:0] term_sync;
  logic [RDSS_NUM_TERMS-1:0] term_active;
  logic [RDSS_FREQ_W-1:0] freq_r [RDSS_NUM_SPEEDS];
  logic [RDSS_FUNC_W-1:0] func_r [RDSS_NUM_TERMS];
  logic [RDSS_NUM_TERMS-1:0] polarity_r;
  logic [1:0] run_source_r;
  logic keypad_dir_r;
  logic keypad_run_r;
  logic fwd_cmd;
  logic rev_cmd;
  logic [RDSS_IDX_W-1:0] idx_nxt;
  rdss_mode_t mode_nxt;
  rdss_mode_t mode_r;
  logic [RDSS_IDX_W-1:0] idx_r;
  logic [RDSS_FREQ_W-1:0] target_r;
  logic [15:0] rdata_r;

  // Matches a terminal's function code against one wanted function.
  function automatic logic [RDSS_NUM_TERMS-1:0] func_hits(input logic [RDSS_FUNC_W-1:0] code);
    logic [RDSS_NUM_TERMS-1:0] hit;
    hit = '0;
    for (int t = 0; t < RDSS_NUM_TERMS; t++) begin
      hit[t] = (func_r[t] == code);
    end
    return hit;
  endfunction

  rdss_sync #(
    .WIDTH(RDSS_NUM_TERMS)
  ) u_sync (
    .clock(clock),
    .srst(srst),
    .clock_en(clock_en),
    .async_in(terminal_in),
    .sync_out(term_sync)
  );

  // A normally closed terminal reads active when its level is low, so an open wire runs the motor.
  assign term_active = term_sync ^ polarity_r;

  always_comb begin
    fwd_cmd = |(func_hits(RDSS_FN_FWD) & term_active);
    rev_cmd = |(func_hits(RDSS_FN_REV) & term_active);
  end

  // Each index bit is the OR of every terminal carrying that select function, so an unassigned bit is 0.
  genvar gb;
  generate
    for (gb = 0; gb < RDSS_IDX_W; gb++) begin : g_sel
      logic sel_bit;
      // A process, so that a function-code write alone also re-evaluates the bit.
      always_comb begin
        sel_bit = |(func_hits(RDSS_FN_SEL0 + RDSS_FUNC_W'(gb)) & term_active);
      end
      assign idx_nxt[gb] = sel_bit;
    end
  endgenerate

  always_comb begin
    mode_nxt = RDSS_STOP;
    unique case (run_source_r)
      RDSS_SRC_TERMINAL: begin
        // Conflicting commands stop the motor rather than pick a side.
        if (fwd_cmd && !rev_cmd) begin
          mode_nxt = RDSS_RUN_FWD;
        end else if (rev_cmd && !fwd_cmd) begin
          mode_nxt = RDSS_RUN_REV;
        end
      end
      RDSS_SRC_KEYPAD: begin
        // The keypad direction bit only matters here, never for terminals.
        if (keypad_run_r) begin
          mode_nxt = keypad_dir_r ? RDSS_RUN_REV : RDSS_RUN_FWD;
        end
      end
      default: mode_nxt = RDSS_STOP;
    endcase
  end

  // No start interlock: a run level already present after reset starts the motor three cycles later, once its terminal carries a run function.
  always_ff @(posedge clock) begin
    if (srst) begin
      mode_r <= RDSS_STOP;
    end else if (clock_en) begin
      mode_r <= mode_nxt;
    end
  end

  // The index and target follow the selects every enabled cycle, running or not.
  always_ff @(posedge clock) begin
    if (srst) begin
      idx_r <= RDSS_IDX_RESET;
      target_r <= RDSS_FREQ_RESET;
    end else if (clock_en) begin
      idx_r <= idx_nxt;
      target_r <= freq_r[idx_nxt];
    end
  end

  // Register writes: frequencies, terminal functions, polarity and control.
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < RDSS_NUM_SPEEDS; i++) begin
        freq_r[i] <= RDSS_FREQ_RESET;
      end
      for (int t = 0; t < RDSS_NUM_TERMS; t++) begin
        func_r[t] <= RDSS_FN_NONE;
      end
      polarity_r <= '0;
      run_source_r <= RDSS_SRC_TERMINAL;
      keypad_dir_r <= 1'h0;
      keypad_run_r <= 1'h0;
    end else if (clock_en && reg_wr) begin
      if (reg_addr < RDSS_OFS_FUNC0) begin
        freq_r[reg_addr[3:0]] <= reg_wdata;
      end else if (reg_addr < RDSS_OFS_POLARITY) begin
        func_r[3'(reg_addr - RDSS_OFS_FUNC0)] <= reg_wdata[RDSS_FUNC_W-1:0];
      end else if (reg_addr == RDSS_OFS_POLARITY) begin
        polarity_r <= reg_wdata[RDSS_NUM_TERMS-1:0];
      end else if (reg_addr == RDSS_OFS_CTRL) begin
        run_source_r <= reg_wdata[RDSS_CTRL_SRC_LSB +: 2];
        keypad_dir_r <= reg_wdata[RDSS_CTRL_KDIR_BIT];
        keypad_run_r <= reg_wdata[RDSS_CTRL_KRUN_BIT];
      end
    end
  end

  // Read data appear the cycle after an enabled strobe and hold until the next enabled edge; unmapped reads return zero.
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_r <= 16'h0000;
    end else if (clock_en) begin
      rdata_r <= 16'h0000;
      if (reg_rd) begin
        if (reg_addr < RDSS_OFS_FUNC0) begin
          rdata_r <= freq_r[reg_addr[3:0]];
        end else if (reg_addr < RDSS_OFS_POLARITY) begin
          rdata_r <= {8'h00, func_r[3'(reg_addr - RDSS_OFS_FUNC0)]};
        end else if (reg_addr == RDSS_OFS_POLARITY) begin
          rdata_r <= {11'h000, polarity_r};
        end else if (reg_addr == RDSS_OFS_CTRL) begin
          rdata_r <= {12'h000, keypad_run_r, keypad_dir_r, run_source_r};
        end else if (reg_addr == RDSS_OFS_STATUS) begin
          rdata_r <= {8'h00, idx_r, 2'h0, (mode_r == RDSS_RUN_REV), (mode_r != RDSS_STOP)};
        end
      end
    end
  end

  assign reg_rdata = rdata_r;
  assign motor_run = (mode_r != RDSS_STOP);
  assign motor_reverse = (mode_r == RDSS_RUN_REV);
  assign speed_index = idx_r;
  assign target_frequency = target_r;
  assign command = '{run: motor_run, reverse: motor_reverse, speed_index: idx_r};
endmodule
`default_nettype wire

// ---- rdss_pkg.sv ----
// Purpose: Constants and types for the run, direction and speed-select decoder.
// Assumes: Five programmable input terminals, sixteen stored target frequencies.
// Notes: Each terminal is configured by a function code and a polarity bit.
`default_nettype none
package rdss_pkg;
  localparam int unsigned RDSS_NUM_TERMS = 5;
  localparam int unsigned RDSS_NUM_SPEEDS = 16;
  localparam int unsigned RDSS_IDX_W = 4;
  localparam int unsigned RDSS_FREQ_W = 16;
  localparam int unsigned RDSS_FUNC_W = 8;
  localparam logic [7:0] RDSS_FN_FWD = 8'h00;
  localparam logic [7:0] RDSS_FN_REV = 8'h01;
  localparam logic [7:0] RDSS_FN_SEL0 = 8'h02;
  localparam logic [7:0] RDSS_FN_NONE = 8'hFF;
  localparam logic [1:0] RDSS_SRC_TERMINAL = 2'h1;
  localparam logic [1:0] RDSS_SRC_KEYPAD = 2'h0;
  localparam logic [RDSS_FREQ_W-1:0] RDSS_FREQ_RESET = 16'h0000;
  localparam logic [RDSS_IDX_W-1:0] RDSS_IDX_RESET = 4'h0;
  // Register offsets for the plain register port.
  localparam logic [7:0] RDSS_OFS_FREQ0 = 8'h00;
  localparam logic [7:0] RDSS_OFS_FUNC0 = 8'h10;
  localparam logic [7:0] RDSS_OFS_POLARITY = 8'h15;
  localparam logic [7:0] RDSS_OFS_CTRL = 8'h16;
  localparam logic [7:0] RDSS_OFS_STATUS = 8'h17;
  localparam int unsigned RDSS_CTRL_SRC_LSB = 0;
  localparam int unsigned RDSS_CTRL_KDIR_BIT = 2;
  localparam int unsigned RDSS_CTRL_KRUN_BIT = 3;
  localparam int unsigned RDSS_STAT_RUN_BIT = 0;
  localparam int unsigned RDSS_STAT_REV_BIT = 1;
  localparam int unsigned RDSS_STAT_IDX_LSB = 4;

  typedef enum logic [1:0] {
    RDSS_STOP,
    RDSS_RUN_FWD,
    RDSS_RUN_REV
  } rdss_mode_t;

  typedef struct packed {
    logic run;
    logic reverse;
    logic [RDSS_IDX_W-1:0] speed_index;
  } rdss_cmd_t;
endpackage
`default_nettype wire

// ---- rdss_sync.sv ----
// Purpose: Two-flop synchroniser for the terminal inputs.
// Assumes: One clock, synchronous active-high reset.
// Notes: The first stage is read only by the second stage.
`default_nettype none
module rdss_sync #(
  parameter int unsigned WIDTH = 5
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic clock_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stable_r;

  always_ff @(posedge clock) begin
    if (srst) begin
      meta_r <= '0;
      stable_r <= '0;
    end else if (clock_en) begin
      meta_r <= async_in;
      stable_r <= meta_r;
    end
  end

  assign sync_out = stable_r;
endmodule
`default_nettype wire

// ---- rdss_field.sv ----
// Purpose: Field contacts driving the five input terminals.
// Assumes: Contacts switch just after a clock edge.
// Notes: Levels are raw; the drive applies polarity itself.
`default_nettype none
module rdss_field (
  input wire logic clock,
  input wire logic srst,
  input wire logic [4:0] level_req,
  output logic [4:0] terminal_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contacts stay open in reset so no run command is live when the drive wakes.
  always_ff @(posedge clock) begin
    terminal_in <= srst ? 5'h00 : level_req;
  end
endmodule
`default_nettype wire

// ---- rdss_checker.sv ----
// Purpose: Port assertions for the terminal decoder.
// Assumes: One clock; srst is synchronous and active high.
// Notes: Four quiet enabled edges flush the input pipeline.
`default_nettype none
module rdss_checker (
  input wire logic clock,
  input wire logic srst,
  input wire logic clock_en,
  input wire logic [4:0] terminal_in,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic motor_run,
  input wire logic motor_reverse,
  input wire logic [3:0] speed_index,
  input wire logic [15:0] target_frequency,
  input wire rdss_pkg::rdss_cmd_t command
);
  timeunit 1ns;
  timeprecision 1ps;
  import rdss_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // A frozen edge keeps the old read data, so only an enabled edge without a read must leave zero.
  a_rdata_idle: assert property ($past(clock_en) && !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("stray read data");
  a_rev_run: assert property (motor_reverse |-> motor_run) else $error("reverse while stopped");
  a_cmd_same: assert property (command == {motor_run, motor_reverse, speed_index})
    else $error("command differs");
  a_status_read: assert property (reg_rd && clock_en && reg_addr == RDSS_OFS_STATUS |=> reg_rdata ==
    {8'h00, $past(speed_index), 2'h0, $past(motor_reverse), $past(motor_run)}) else $error("status wrong");
  a_unmapped_zero: assert property (reg_rd && clock_en && reg_addr > RDSS_OFS_STATUS |=>
    reg_rdata == 16'h0000) else $error("unmapped read");
  a_frozen_hold: assert property (!clock_en |=> $stable({motor_run, speed_index, target_frequency}))
    else $error("moved while frozen");
  a_quiet_hold: assert property ((clock_en && !reg_wr && $stable(terminal_in)) [*4] |=>
    $stable({motor_run, speed_index, target_frequency})) else $error("moved without cause");
  a_reset_out: assert property ($fell(srst) |-> {motor_run, speed_index, target_frequency} == 21'h0)
    else $error("outputs not cleared");
  c_rev: cover property (motor_reverse);
  c_top: cover property (speed_index == 4'hF);
  c_stop: cover property (motor_run ##1 !motor_run);
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the terminal decoder.
// Assumes: Outputs settle within three enabled edges.
// Notes: Each round draws functions, polarity, control and levels.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rdss_pkg::*;
  logic clock = 0, srst = 1, clock_en = 1, reg_wr = 0, reg_rd = 0, rd_seen = 0, run, rv, motor_run, motor_reverse;
  logic [3:0] speed_index, ctl;
  logic [4:0] level_req = 0, terminal_in, pol;
  logic [5:0] fn;
  logic [7:0] reg_addr = 0, rd_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata, target_frequency, freq [16];
  logic [31:0] seed = 31, e, exp_q [$];
  rdss_cmd_t command;
  int mismatches = 0, n_checks = 0, rot;
  rdss_top i_dut (.*);
  rdss_field i_field (.clock(clock), .srst(srst), .level_req(level_req), .terminal_in(terminal_in));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial forever #2 clock = ~clock;
  initial begin
    #20us;
    mismatches++;
    conclude();
  end
  always @(posedge clock) begin
    if (rd_seen) begin
      e = exp_q.pop_front();
      check("read data", reg_rdata, e[31:16]);
      check("target", target_frequency, e[15:0]);
      // Status reads also hold the output pins to the same expectation.
      if (rd_addr == RDSS_OFS_STATUS) begin
        check("pins", {8'h00, speed_index, 2'h0, motor_reverse, motor_run}, e[31:16]);
        check("command", {8'h00, command.speed_index, 2'h0, command.reverse, command.run}, e[31:16]);
      end
    end
    rd_seen <= reg_rd && clock_en;
    rd_addr <= reg_addr;
  end
  initial begin
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 16; i++) begin
      freq[i] = 16'(rnd());
      bus(1'b1, 8'(i), freq[i]);
    end
    exp_q.push_back({16'h0001, freq[0]});
    bus(1'b0, RDSS_OFS_CTRL, 16'h0000);
    exp_q.push_back({16'h0000, freq[0]});
    bus(1'b0, 8'h3C, 16'h0000);
    for (int n = 0; n < 24; n++) begin
      rot = int'(rnd() % 6);
      for (int t = 0; t < 5; t++) bus(1'b1, RDSS_OFS_FUNC0 + 8'(t), 16'((t + rot) % 6));
      pol = 5'(rnd());
      ctl = 4'(rnd());
      bus(1'b1, RDSS_OFS_POLARITY, {11'h0, pol});
      bus(1'b1, RDSS_OFS_CTRL, {12'h0, ctl});
      reg_wr <= 1'b0;
      clock_en <= 1'b0;
      level_req <= 5'(rnd());
      repeat (2) @(posedge clock);
      clock_en <= 1'b1;
      repeat (6) @(posedge clock);
      fn = 6'h00;
      for (int t = 0; t < 5; t++) fn[(t + rot) % 6] = level_req[t] ^ pol[t];
      run = ctl[1:0] == RDSS_SRC_TERMINAL ? fn[0] ^ fn[1] : ctl[1:0] == RDSS_SRC_KEYPAD && ctl[3];
      rv = run && (ctl[1:0] == RDSS_SRC_TERMINAL ? fn[1] : ctl[2]);
      exp_q.push_back({8'h00, fn[5:2], 2'h0, rv, run, freq[fn[5:2]]});
      bus(1'b0, RDSS_OFS_STATUS, 16'h0000);
    end
    // A second reset with run and select levels requested: the field holds its contacts open in reset and drives them from the first edge after it.
    reg_rd <= 1'b0;
    srst <= 1'b1;
    level_req <= 5'h03;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    bus(1'b1, RDSS_OFS_FREQ0 + 8'h01, 16'hA5C3);
    bus(1'b1, RDSS_OFS_FUNC0, {8'h00, RDSS_FN_FWD});
    // Only the lowest select bit is assigned, as a controller using few speeds should do.
    bus(1'b1, RDSS_OFS_FUNC0 + 8'h01, {8'h00, RDSS_FN_SEL0});
    reg_wr <= 1'b0;
    repeat (4) @(posedge clock);
    exp_q.push_back({16'h0011, 16'hA5C3});
    bus(1'b0, RDSS_OFS_STATUS, 16'h0000);
    reg_rd <= 1'b0;
    repeat (3) @(posedge clock);
    conclude();
  end
endmodule
bind rdss_top rdss_checker i_chk (.*);
`default_nettype wire
